// File: logic/pdc_pkg.sv
// pdc_pkg.sv: constants for the pll distribution configuration block
// assumes: register port with 10-bit address and 8-bit data, 25 MHz clock
//
// How it works
// - power field 01 powers down, 00 runs
// - bypass bit skips the vco divider
// - source bit zero selects external clock input
// - polarity bit zero positive, one negative
// - settings apply only after update write 0x01
// - two-bit field sets antibacklash pulse width
// - charge pump: hi-z, normal, up, down
// - eight charge pump current steps
// - detector compares reference and feedback edges
// - polarity applies only to external oscillator
// - calibration bit starts vco centring when the vco is the active source
package pdc_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [9:0] PDC_OFS_MODE   = 10'h010; // pll mode control
  localparam logic [9:0] PDC_OFS_ABL    = 10'h017; // antibacklash control
  localparam logic [9:0] PDC_OFS_CAL    = 10'h018; // vco calibration control
  localparam logic [9:0] PDC_OFS_DIST   = 10'h1e1; // distribution input select
  localparam logic [9:0] PDC_OFS_UPD    = 10'h232; // settings update strobe
  localparam logic [9:0] PDC_OFS_STAT   = 10'h233; // active state readback

  // ****************************************************************
  // field positions and values
  // ****************************************************************
  localparam int         PDC_POL_BIT    = 7;       // detector polarity
  localparam int         PDC_CPM_LSB    = 4;       // charge pump mode lsb
  localparam int         PDC_CPI_LSB    = 2;       // pump current lsb
  localparam int         PDC_BYP_BIT    = 0;       // divider bypass
  localparam int         PDC_SRC_BIT    = 1;       // source select
  localparam logic [1:0] PDC_PWR_ON     = 2'h0;    // normal operation
  localparam logic [1:0] PDC_PWR_DOWN   = 2'h1;    // async power-down
  localparam logic [7:0] PDC_UPD_GO     = 8'h01;   // update command

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] PDC_RST_MODE   = 8'h01;   // pll off
  localparam logic [7:0] PDC_RST_ABL    = 8'h00;   // shortest pulse
  localparam logic [7:0] PDC_RST_CAL    = 8'h00;   // no calibration
  localparam logic [7:0] PDC_RST_DIST   = 8'h00;   // divider used, clk in

  // ****************************************************************
  // charge pump modes and timing
  // ****************************************************************
  typedef enum logic [2:0] {
    PDC_CP_HIZ  = 3'h0,
    PDC_CP_UP   = 3'h1,
    PDC_CP_DOWN = 3'h2,
    PDC_CP_NORM = 3'h3
  } pdc_cpmode_type;

  localparam int         PDC_CLK_MHZ    = 25;      // system clock rate
  localparam int         PDC_CAL_US     = 40;      // calibration time, us
  localparam int         PDC_CAL_CYC    = PDC_CAL_US * PDC_CLK_MHZ;
  localparam int         PDC_ABL_STEP   = 1;       // cycles added to the width setting

endpackage

// File: logic/pdc_pfd.sv
// pdc_pfd.sv: phase frequency detector with antibacklash stretch
// assumes: divider edges already synchronised to CLK
`timescale 1ns/1ps
module pdc_pfd
  import pdc_pkg::*;
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       CE,
  // divider edges and control
  input  wire logic       ref_edge,
  input  wire logic       fb_edge,
  input  wire logic       invert,
  input  wire logic [1:0] abl_width,
  // pump requests
  output logic            up,
  output logic            down
);

  logic       up_q, up_d;     // reference leads
  logic       dn_q, dn_d;     // feedback leads
  logic [2:0] abl_q, abl_d;   // antibacklash counter

  // ****************************************************************
  // detector state
  // ****************************************************************
  // reset both flops when both lead; stretch with antibacklash
  always_comb begin
    up_d  = up_q | ref_edge;
    dn_d  = dn_q | fb_edge;
    abl_d = abl_q;
    if (abl_q != 3'h0) begin
      abl_d = abl_q - 3'h1;
      if (abl_q == 3'h1) begin
        up_d = 1'b0;
        dn_d = 1'b0;
      end
    end else if (up_d && dn_d) begin
      abl_d = {1'b0, abl_width} + 3'(PDC_ABL_STEP);
    end
  end

  // register only
  always_ff @(posedge CLK) begin
    if (RST) begin
      up_q  <= 1'b0;
      dn_q  <= 1'b0;
      abl_q <= 3'h0;
    end else if (CE) begin
      up_q  <= up_d;
      dn_q  <= dn_d;
      abl_q <= abl_d;
    end
  end

  // polarity swap for negative-slope oscillators
  assign up   = invert ? dn_q : up_q;
  assign down = invert ? up_q : dn_q;

  a_pfd_abl_end: assert property (@(posedge CLK) disable iff (RST)
    (CE && abl_q == 3'h1) |=> (!up_q && !dn_q))
    else $error("detector not cleared after antibacklash");

endmodule

// File: logic/pdc_top.sv
// pdc_top.sv: pll and distribution input configuration block
// assumes: register port on CLK, divider edge inputs from other domains
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module pdc_top
  import pdc_pkg::*;
#(
  parameter int CAL_CYCLES = PDC_CAL_CYC   // calibration duration
)(
  // clock, reset, enable
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       CE,
  // register port
  input  wire logic [9:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // divider inputs (asynchronous)
  input  wire logic       REF_DIV,
  input  wire logic       FB_DIV,
  // pll controls
  output logic            PLL_PD,
  output logic            CP_UP,
  output logic            CP_DOWN,
  output logic            CP_HIZ,
  output logic      [2:0] CP_CURRENT,
  output logic      [1:0] ABL_WIDTH,
  // distribution routing
  output logic            DIV_BYPASS,
  output logic            SRC_VCO,
  // vco calibration
  output logic            CAL_BUSY
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0] st_mode_q, st_mode_d;   // staged mode
  logic [7:0] st_abl_q,  st_abl_d;    // staged antibacklash
  logic [7:0] st_cal_q,  st_cal_d;    // staged calibration
  logic [7:0] st_dist_q, st_dist_d;   // staged routing
  logic [7:0] ac_mode_q, ac_mode_d;   // active mode
  logic [7:0] ac_abl_q,  ac_abl_d;    // active antibacklash
  logic [7:0] ac_cal_q,  ac_cal_d;    // active calibration
  logic [7:0] ac_dist_q, ac_dist_d;   // active routing
  logic [7:0] rdata_q,   rdata_d;     // read data
  logic       commit;                 // update strobe seen
  logic [2:0] ref_s_q, ref_s_d;       // ref sync and edge
  logic [2:0] fb_s_q,  fb_s_d;        // feedback sync and edge
  logic       ref_edge;               // synchronised ref rise
  logic       fb_edge;                // synchronised fb rise
  logic       pfd_up;                 // detector up
  logic       pfd_dn;                 // detector down
  logic       pll_on;                 // pll running
  logic       ext_osc;                // external oscillator in loop
  logic [2:0] cp_mode;                // active pump mode

  // one-hot calibration sequencer states
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN  = 3'b010,
    CAL_DONE = 3'b100
  } pdc_cal_type;
  pdc_cal_type cal_q, cal_d;          // calibration state
  logic [31:0] calc_q, calc_d;        // calibration counter

  // read decode shared by read port and state readback
  function automatic logic [7:0] pdc_reg_read(input logic [9:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      PDC_OFS_MODE: v = st_mode_q;
      PDC_OFS_ABL:  v = st_abl_q;
      PDC_OFS_CAL:  v = st_cal_q;
      PDC_OFS_DIST: v = st_dist_q;
      PDC_OFS_STAT: v = {4'h0, cal_q == CAL_DONE, cal_q == CAL_RUN, ac_dist_q[1:0]};
      default:      v = 8'h00;   // unmapped and update read zero
    endcase
    return v;
  endfunction

  // only the exact update code commits; other values at this offset do nothing
  assign commit = WR && (ADDR == PDC_OFS_UPD) && (WDATA == PDC_UPD_GO);

  // ****************************************************************
  // staging and active registers
  // ****************************************************************
  // writes land in staging; active copies wait for the update strobe
  always_comb begin
    st_mode_d = st_mode_q;
    st_abl_d  = st_abl_q;
    st_cal_d  = st_cal_q;
    st_dist_d = st_dist_q;
    if (WR) begin
      case (ADDR)
        PDC_OFS_MODE: st_mode_d = WDATA;
        PDC_OFS_ABL:  st_abl_d  = WDATA;
        PDC_OFS_CAL:  st_cal_d  = WDATA;
        PDC_OFS_DIST: st_dist_d = WDATA;
        default:      st_mode_d = st_mode_q;
      endcase
    end
    // copy everything in one cycle
    ac_mode_d = commit ? st_mode_q : ac_mode_q;
    ac_abl_d  = commit ? st_abl_q  : ac_abl_q;
    ac_cal_d  = commit ? st_cal_q  : ac_cal_q;
    ac_dist_d = commit ? st_dist_q : ac_dist_q;
    rdata_d   = RD ? pdc_reg_read(ADDR) : 8'h00;
  end

  // register only; reset loads the power-up defaults into both copies
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_mode_q <= PDC_RST_MODE;
      st_abl_q  <= PDC_RST_ABL;
      st_cal_q  <= PDC_RST_CAL;
      st_dist_q <= PDC_RST_DIST;
      ac_mode_q <= PDC_RST_MODE;
      ac_abl_q  <= PDC_RST_ABL;
      ac_cal_q  <= PDC_RST_CAL;
      ac_dist_q <= PDC_RST_DIST;
      rdata_q   <= 8'h00;
    end else if (CE) begin
      st_mode_q <= st_mode_d;
      st_abl_q  <= st_abl_d;
      st_cal_q  <= st_cal_d;
      st_dist_q <= st_dist_d;
      ac_mode_q <= ac_mode_d;
      ac_abl_q  <= ac_abl_d;
      ac_cal_q  <= ac_cal_d;
      ac_dist_q <= ac_dist_d;
      rdata_q   <= rdata_d;
    end
  end

  // read data is zero outside the cycle after a read
  assign RDATA = rdata_q;

  // ****************************************************************
  // divider input synchronisers
  // ****************************************************************
  // two flops, then a third for rising-edge detect
  always_comb begin
    ref_s_d = {ref_s_q[1:0], REF_DIV};
    fb_s_d  = {fb_s_q[1:0],  FB_DIV};
  end

  // reset to the idle low level so no false edge follows reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      ref_s_q <= 3'h0;
      fb_s_q  <= 3'h0;
    end else if (CE) begin
      ref_s_q <= ref_s_d;
      fb_s_q  <= fb_s_d;
    end
  end

  // edges are dropped while the pll is not running
  assign ref_edge = ref_s_q[1] & ~ref_s_q[2] & pll_on;
  assign fb_edge  = fb_s_q[1]  & ~fb_s_q[2]  & pll_on;

  // ****************************************************************
  // phase detector and charge pump
  // ****************************************************************
  // decode of the active mode and routing fields
  assign pll_on  = (ac_mode_q[1:0] == PDC_PWR_ON);
  assign PLL_PD  = (ac_mode_q[1:0] == PDC_PWR_DOWN);
  assign ext_osc = ~ac_dist_q[PDC_SRC_BIT];
  assign cp_mode = ac_mode_q[PDC_CPM_LSB +: 3];

  // polarity swap only with an external oscillator in the loop
  pdc_pfd u_pfd (
    .CLK       (CLK),
    .RST       (RST),
    .CE        (CE),
    .ref_edge  (ref_edge),
    .fb_edge   (fb_edge),
    .invert    (ext_osc & ac_mode_q[PDC_POL_BIT]),
    .abl_width (ac_abl_q[1:0]),
    .up        (pfd_up),
    .down      (pfd_dn)
  );

  // pump drive by mode; power-down forces hi-z
  always_comb begin
    CP_UP   = 1'b0;
    CP_DOWN = 1'b0;
    CP_HIZ  = 1'b1;
    if (pll_on) begin
      case (cp_mode)
        PDC_CP_NORM: begin
          CP_HIZ  = 1'b0;
          CP_UP   = pfd_up;
          CP_DOWN = pfd_dn;
        end
        PDC_CP_UP: begin
          CP_HIZ = 1'b0;
          CP_UP  = 1'b1;
        end
        PDC_CP_DOWN: begin
          CP_HIZ  = 1'b0;
          CP_DOWN = 1'b1;
        end
        default: CP_HIZ = 1'b1;
      endcase
    end
  end

  // pump current is a full 3-bit step code, eight settings,
  // kept beside the antibacklash width so both load on one write
  assign CP_CURRENT = ac_abl_q[PDC_CPI_LSB +: 3];
  assign ABL_WIDTH  = ac_abl_q[1:0];
  assign DIV_BYPASS = ac_dist_q[PDC_BYP_BIT];
  assign SRC_VCO    = ac_dist_q[PDC_SRC_BIT];

  // ****************************************************************
  // vco calibration sequencer
  // ****************************************************************
  // next state and countdown of the calibration run
  always_comb begin
    cal_d  = cal_q;
    calc_d = calc_q;
    case (cal_q)
      CAL_IDLE, CAL_DONE: begin
        // rising commit of calibration bit starts a run, only with the vco already selected as source
        if (commit && st_cal_q[0] && !ac_cal_q[0] && SRC_VCO) begin
          cal_d  = CAL_RUN;
          calc_d = 32'(CAL_CYCLES);
        end
      end
      CAL_RUN: begin
        calc_d = calc_q - 32'h1;
        if (calc_q == 32'h1) begin
          cal_d = CAL_DONE;
        end
      end
      default: cal_d = CAL_IDLE;
    endcase
  end

  // register only
  always_ff @(posedge CLK) begin
    if (RST) begin
      cal_q  <= CAL_IDLE;
      calc_q <= 32'h0;
    end else if (CE) begin
      cal_q  <= cal_d;
      calc_q <= calc_d;
    end
  end

  // busy for exactly the run state
  assign CAL_BUSY = (cal_q == CAL_RUN);

  // ****************************************************************
  // checks
  // ****************************************************************
  // update strobe taken on an enabled edge
  sequence s_commit;
    CE && commit;
  endsequence

  // update that raises the calibration bit with the vco selected
  sequence s_cal_go;
    s_commit ##0 (st_cal_q[0] && !ac_cal_q[0] && SRC_VCO && cal_q != CAL_RUN);
  endsequence

  a_commit_copies: assert property (@(posedge CLK) disable iff (RST)
    s_commit |=> (ac_dist_q == $past(st_dist_q)))
    else $error("routing not copied on update");

  a_hold_noupd: assert property (@(posedge CLK) disable iff (RST)
    (!commit) |=> $stable(ac_mode_q))
    else $error("active mode changed without update");

  a_freeze_ce: assert property (@(posedge CLK) disable iff (RST)
    (!CE) |=> ($stable(st_mode_q) && $stable(ac_mode_q) && $stable(cal_q)))
    else $error("state moved while clock enable low");

  a_pd_hiz: assert property (@(posedge CLK) disable iff (RST)
    PLL_PD |-> (CP_HIZ && !CP_UP && !CP_DOWN))
    else $error("pump active during power-down");

  a_bypass_map: assert property (@(posedge CLK) disable iff (RST)
    s_commit |=> (DIV_BYPASS == $past(st_dist_q[PDC_BYP_BIT])))
    else $error("bypass not applied on update");

  a_src_map: assert property (@(posedge CLK) disable iff (RST)
    s_commit |=> (SRC_VCO == $past(st_dist_q[PDC_SRC_BIT])))
    else $error("source select not applied on update");

  a_pump_up: assert property (@(posedge CLK) disable iff (RST)
    (pll_on && cp_mode == PDC_CP_UP) |-> (CP_UP && !CP_DOWN))
    else $error("forced up not driven");

  a_vco_pol: assert property (@(posedge CLK) disable iff (RST)
    (SRC_VCO && pll_on && cp_mode == PDC_CP_NORM) |-> (CP_UP == u_pfd.up_q && CP_DOWN == u_pfd.dn_q))
    else $error("polarity swapped on internal vco");

  a_cal_len: assert property (@(posedge CLK) disable iff (RST)
    s_cal_go |=> (CAL_BUSY && calc_q == 32'(CAL_CYCLES)))
    else $error("calibration did not start");

  a_abl_out: assert property (@(posedge CLK) disable iff (RST)
    s_commit |=> (ABL_WIDTH == $past(st_abl_q[1:0])))
    else $error("antibacklash width not applied");

endmodule

// File: testbench/pdc_src_model.sv
// pdc_src_model.sv: divider edge source for the reference and vco paths
// assumes: edges free of CLK, static while run is low
`timescale 1ns/1ps
module pdc_src_model #(
  parameter int REF_HALF_NS = 200, // reference divider half period
  parameter int FB_HALF_NS  = 264  // feedback half period, never on a CLK rise
)(
  // control
  input  wire logic run,
  // divider outputs
  output logic      ref_div,
  output logic      fb_div
);
  // ********
  // dividers
  // ********
  // reference divider toggles only while run is high
  initial begin
    ref_div = 1'b0;
    forever begin
      #(REF_HALF_NS);
      ref_div = run ? ~ref_div : 1'b0;
    end
  end
  // feedback divider is slower, so the loop sees ref lead
  initial begin
    fb_div = 1'b0;
    forever begin
      #(FB_HALF_NS);
      fb_div = run ? ~fb_div : 1'b0;
    end
  end
endmodule

// File: testbench/tb_pll_distribution_config.sv
// tb_pll_distribution_config.sv: self-checking bench for pdc_top
// assumes: 25 MHz clock, pdc_src_model drives the divider inputs
`timescale 1ns/1ps
module tb_pll_distribution_config import pdc_pkg::*;;
  // ********
  // signals
  // ********
  logic       CLK, RST, CE, WR, RD, run;
  logic [9:0] ADDR;
  logic [7:0] WDATA, RDATA;
  logic       ref_div, fb_div, PLL_PD, CP_UP, CP_DOWN, CP_HIZ;
  logic [2:0] CP_CURRENT;
  logic [1:0] ABL_WIDTH;
  logic       DIV_BYPASS, SRC_VCO, CAL_BUSY;
  int         errors, total_checks, ups, downs, n;

  pdc_top #(.CAL_CYCLES(5)) uut (
    .CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .REF_DIV(ref_div), .FB_DIV(fb_div), .PLL_PD(PLL_PD),
    .CP_UP(CP_UP), .CP_DOWN(CP_DOWN), .CP_HIZ(CP_HIZ), .CP_CURRENT(CP_CURRENT),
    .ABL_WIDTH(ABL_WIDTH), .DIV_BYPASS(DIV_BYPASS), .SRC_VCO(SRC_VCO), .CAL_BUSY(CAL_BUSY)
  );
  pdc_src_model u_src (.run(run), .ref_div(ref_div), .fb_div(fb_div));

  // ********
  // tasks
  // ********
  // compare one value, count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask
  // read, data stands in the following cycle
  task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string what);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    #1;
    chk(RDATA, exp, what);
  endtask
  // write the update command and let outputs settle
  task automatic commit;
    wr(PDC_OFS_UPD, PDC_UPD_GO);
    #1;
  endtask
  // count pump up and down cycles over a window
  task automatic measure;
    ups = 0;
    downs = 0;
    repeat (400) begin
      @(posedge CLK);
      #1;
      ups += (CP_UP === 1'b1);
      downs += (CP_DOWN === 1'b1);
    end
  endtask
  // counts, verdict and stop
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ********
  // clock and watchdog
  // ********
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    end_sim();
  end

  // ********
  // main sequence
  // ********
  initial begin
    RST = 1'b1; CE = 1'b1; WR = 1'b0; RD = 1'b0; run = 1'b0;
    ADDR = 10'h000; WDATA = 8'h00; errors = 0; total_checks = 0;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    #1;
    // reset state
    chk(PLL_PD, 8'h01, "pd at reset");
    chk(CP_HIZ, 8'h01, "hiz at reset");
    chk({SRC_VCO, DIV_BYPASS}, 8'h00, "route at reset");
    rd(PDC_OFS_MODE, PDC_RST_MODE, "mode reset");
    rd(PDC_OFS_ABL, PDC_RST_ABL, "abl reset");
    rd(PDC_OFS_DIST, PDC_RST_DIST, "dist reset");
    rd(10'h100, 8'h00, "unmapped read");
    rd(PDC_OFS_UPD, 8'h00, "update read");
    // clock source below divider limit, bypass route
    wr(PDC_OFS_DIST, 8'h01);
    wr(PDC_OFS_MODE, 8'h3c);
    wr(PDC_OFS_ABL, 8'h1f);
    rd(PDC_OFS_DIST, 8'h01, "staged readback");
    wr(PDC_OFS_UPD, 8'h02);
    #1;
    chk({PLL_PD, DIV_BYPASS}, 8'h02, "held before update");
    commit();
    chk({PLL_PD, DIV_BYPASS}, 8'h01, "applied by update");
    chk(CP_CURRENT, 8'h07, "current top step");
    chk(ABL_WIDTH, 8'h03, "abl width");
    run <= 1'b1;
    measure();
    chk(ups > downs, 8'h01, "ref lead pumps up");
    wr(PDC_OFS_MODE, 8'hbc);
    commit();
    measure();
    chk(downs > ups, 8'h01, "negative polarity");
    // fixed pump modes with current and width steps
    for (int i = 0; i < 3; i++) begin
      wr(PDC_OFS_MODE, {1'b0, 3'(i), 2'(i), 2'h0});
      wr(PDC_OFS_ABL, {3'h0, 3'(3 * i), 2'(i)});
      commit();
      chk({CP_HIZ, CP_UP, CP_DOWN}, 8'(4 >> i), "pump mode");
      chk(CP_CURRENT, 8'(3 * i), "pump current");
      chk(ABL_WIDTH, 8'(i), "abl step");
    end
    // internal vco: polarity bit ignored
    wr(PDC_OFS_DIST, 8'h02);
    wr(PDC_OFS_MODE, 8'hbc);
    commit();
    chk({SRC_VCO, DIV_BYPASS}, 8'h02, "vco via divider");
    measure();
    chk(ups > downs, 8'h01, "fixed polarity on vco");
    // calibration at setup, dividers kept running
    wr(PDC_OFS_CAL, 8'h01);
    commit();
    for (n = 0; n < 3 && CAL_BUSY !== 1'b1; n++) begin
      @(posedge CLK);
      #1;
    end
    chk(CAL_BUSY, 8'h01, "calibration starts");
    for (n = 0; n < 20 && CAL_BUSY === 1'b1; n++) begin
      @(posedge CLK);
      #1;
    end
    chk(8'(n), 8'h05, "calibration length");
    rd(PDC_OFS_STAT, 8'h0a, "status after cal");
    // clock enable low: the write is not taken
    @(posedge CLK);
    CE <= 1'b0;
    wr(PDC_OFS_MODE, 8'h01);
    CE <= 1'b1;
    rd(PDC_OFS_MODE, 8'hbc, "frozen by enable");
    // back to power-down
    wr(PDC_OFS_MODE, 8'h01);
    commit();
    chk(PLL_PD, 8'h01, "power-down");
    end_sim();
  end
endmodule
